/* shared/scs_pkg.sv */
package scs_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] MAIN_CTRL_OFFS = 8'h00;
  localparam logic [7:0] AUX_CTRL_OFFS = 8'h04;
  localparam logic [7:0] TUNE_CTRL_OFFS = 8'h08;

  // main control field positions
  localparam int MAIN_IDLE_BIT = 7;
  localparam int MAIN_IFS_LSB = 4;
  localparam int MAIN_PRIRUN_BIT = 3;
  localparam int MAIN_HFSTAB_BIT = 2;
  localparam int MAIN_SCS_LSB = 0;
  // aux control field positions
  localparam int AUX_MULRUN_BIT = 7;
  localparam int AUX_SECRUN_BIT = 6;
  localparam int AUX_MFSEL_BIT = 4;
  localparam int AUX_SECGO_BIT = 3;
  localparam int AUX_PRIDRV_BIT = 2;
  localparam int AUX_MFSTAB_BIT = 1;
  localparam int AUX_LFSTAB_BIT = 0;
  // tune control field positions
  localparam int TUNE_LFSRC_BIT = 7;
  localparam int TUNE_MULEN_BIT = 6;

  // reset values
  localparam logic [1:0] SCS_RESET = 2'h0;
  localparam logic [2:0] IFS_RESET = 3'h3;
  localparam logic PRIDRV_RESET = 1'b1;

  // frequency select codes
  localparam logic [2:0] IFS_DIV1 = 3'h7;
  localparam logic [2:0] IFS_DIV16 = 3'h3;
  localparam logic [2:0] IFS_CODE2 = 3'h2;
  localparam logic [2:0] IFS_CODE1 = 3'h1;
  // divider ratios as powers of two
  localparam logic [3:0] DIV_HF_C2 = 4'h5;
  localparam logic [3:0] DIV_HF_C1 = 4'h6;
  localparam logic [3:0] DIV_HF_C0 = 4'h9;
  localparam logic [3:0] DIV_MF_C0 = 4'h4;
  localparam logic [3:0] DIV_ONE = 4'h0;
  localparam logic [3:0] DIV_TWO = 4'h1;

  // primary mode fuse codes
  localparam logic [3:0] MODE_INT_FIRST = 4'h8;
  localparam logic [3:0] MODE_INT_LAST = 4'h9;
  localparam logic [3:0] MODE_EXT_LAST = 4'h7;
  localparam logic [3:0] MODE_CLKOUT_A = 4'h9;
  localparam logic [3:0] MODE_CLKOUT_B = 4'h3;
  localparam logic [3:0] MODE_GPIO_A = 4'h8;
  localparam logic [3:0] MODE_GPIO_B = 4'h5;

  // clock switch interval
  localparam int CLK_PERIOD_NS = 50;
  localparam int SWITCH_NS = 100;
  localparam logic [2:0] SWITCH_CNT = 3'((SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} scs_src_t;
  typedef enum logic [1:0] {INT_HF, INT_MF, INT_LF} scs_int_osc_t;
  typedef enum logic [1:0] {PIN_OSC, PIN_GPIO, PIN_CLKOUT} scs_pin_role_t;
  typedef enum logic {SW_STEADY, SW_MOVING} scs_sw_state_t;

  // internal oscillator block setting
  typedef struct packed {
    scs_int_osc_t src;
    logic [3:0] div_log2;
  } scs_int_clk_t;

  // configuration fuses
  typedef struct packed {
    logic [3:0] primary_mode_fuse;
    logic multiplier_fuse;
    logic two_speed_startup_fuse;
  } scs_fuse_t;

endpackage

/* verilog/scs_clock_select.sv */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - select field: 00 primary, 01 secondary, 1x internal
// - ordinary reset clears the select field, power-on reset alone does not
// - source moves after short switching interval
// - codes 111..011 give high osc /1../16
// - plain mode: 010,001 /32,/64; 000 low osc
// - low source bit: 000 is high /512
// - medium select: medium, /2; 000 low or medium/16
// - frequency change takes effect one cycle after the write
// - reset sets frequency code to 1 MHz
// - watchdog always runs from low oscillator
// - sleep enters idle when idle bit set
// - bit 3 shows primary running, fuse-dependent reset
// - bit 2 shows high oscillator stable
// - aux bit 7 shows multiplier is clocking
// - aux bit 6 shows secondary is clocking
// - secondary start bit, power-on reset only
// - primary drive bit, resets to one
// - aux bits 1,0 show medium, low stable
// - fuse codes free second pin or clkout
// - primary mode comes from fuse field
module scs_clock_select
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scs_fuse_t fuse_raw,
  input wire logic [2:0] osc_stable_raw,
  input wire logic primary_ready_raw,
  input wire logic secondary_other_req,
  input wire logic sleep_exec,
  output scs_src_t sys_clock_source,
  output scs_int_clk_t int_clk_setting,
  output logic multiplier_select,
  output logic secondary_osc_enable,
  output logic primary_drive_enable,
  output logic watchdog_low_osc_sel,
  output scs_pin_role_t pin_role,
  output logic divided_clock_output,
  output logic switch_busy,
  output logic idle_enter,
  output logic sleep_enter
);

  // ----------------------------------------------------------------
  // reset and input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 3 + 1 + 6;

  logic [1:0] rst_pipe;
  logic [1:0] por_pipe;
  logic rst_n;
  logic por_n;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] sync_in;

  // release both resets through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge por_resetn) begin
    if (!por_resetn) begin
      por_pipe <= 2'h0;
    end else begin
      por_pipe <= {por_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];
  assign por_n = por_pipe[1];
  assign sync_in = {osc_stable_raw, primary_ready_raw, fuse_raw};

  // pin inputs: meta flop feeds only the second flop
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_meta[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          sync_meta[gi] <= sync_in[gi];
          sync_q[gi] <= sync_meta[gi];
        end
      end
    end
  endgenerate

  scs_fuse_t fuse;
  logic hf_stable;
  logic mf_stable;
  logic lf_stable;
  logic primary_ready;

  assign fuse = sync_q[5:0];
  assign primary_ready = sync_q[6];
  assign lf_stable = sync_q[7];
  assign mf_stable = sync_q[8];
  assign hf_stable = sync_q[9];

  // ----------------------------------------------------------------
  // software registers and apb slave
  // ----------------------------------------------------------------
  logic idle_on_sleep_enable;
  logic [2:0] internal_freq_select;
  logic [1:0] sys_clock_select;
  logic medium_osc_select;
  logic secondary_osc_start;
  logic primary_drive_on;
  logic low_freq_source_bit;
  logic multiplier_enable;
  logic primary_running_status;
  logic multiplier_running_status;
  logic secondary_running_status;

  wire access = psel && penable;
  wire wr_take = access && pready && pwrite;
  wire hit_main = paddr == MAIN_CTRL_OFFS;
  wire hit_aux = paddr == AUX_CTRL_OFFS;
  wire hit_tune = paddr == TUNE_CTRL_OFFS;
  wire hit_any = hit_main || hit_aux || hit_tune;
  wire wr_main = wr_take && hit_main;
  wire wr_aux = wr_take && hit_aux;
  wire wr_tune = wr_take && hit_tune;

  // register images as software reads them
  // high stable readback
  wire [7:0] main_image = {idle_on_sleep_enable, internal_freq_select, primary_running_status,
                           hf_stable, sys_clock_select};
  wire [7:0] aux_image = {multiplier_running_status, secondary_running_status, 1'b0,
                          medium_osc_select, secondary_osc_start, primary_drive_on,
                          mf_stable, lf_stable};
  wire [7:0] tune_image = {low_freq_source_bit, multiplier_enable, 6'h00};
  wire [7:0] read_sel = hit_main ? main_image : hit_aux ? aux_image : hit_tune ? tune_image : 8'h00;

  // one wait state: ready rises in the second access cycle
  wire next_pready = access && !pready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pready && !hit_any;
      prdata <= next_pready ? {24'h00_0000, read_sel} : 32'h0000_0000;
    end
  end

  // main control fields, reset by ordinary reset only; frequency code loads IFS_RESET
  // select field cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_on_sleep_enable <= 1'b0;
      internal_freq_select <= IFS_RESET;
      sys_clock_select <= SCS_RESET;
    end else if (wr_main) begin
      idle_on_sleep_enable <= pwdata[MAIN_IDLE_BIT];
      internal_freq_select <= pwdata[MAIN_IFS_LSB +: 3];
      sys_clock_select <= pwdata[MAIN_SCS_LSB +: 2];
    end
  end

  // aux and tune fields on ordinary reset
  // drive bit resets to one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      medium_osc_select <= 1'b0;
      primary_drive_on <= PRIDRV_RESET;
      low_freq_source_bit <= 1'b0;
      multiplier_enable <= 1'b0;
    end else begin
      if (wr_aux) begin
        medium_osc_select <= pwdata[AUX_MFSEL_BIT];
        primary_drive_on <= pwdata[AUX_PRIDRV_BIT];
      end
      if (wr_tune) begin
        low_freq_source_bit <= pwdata[TUNE_LFSRC_BIT];
        multiplier_enable <= pwdata[TUNE_MULEN_BIT];
      end
    end
  end

  // start bit survives all but power-on reset
  // power-on reset only
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      secondary_osc_start <= 1'b0;
    end else if (wr_aux) begin
      secondary_osc_start <= pwdata[AUX_SECGO_BIT];
    end
  end

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  // select field decode
  function automatic scs_src_t decode_select(input logic [1:0] code);
    if (code[1]) begin
      decode_select = SRC_INTERNAL;
    end else if (code[0]) begin
      decode_select = SRC_SECONDARY;
    end else begin
      decode_select = SRC_PRIMARY;
    end
  endfunction

  function automatic scs_int_clk_t decode_freq(input logic [2:0] code, input logic lfsrc,
                                               input logic mfsel);
    scs_int_clk_t r;
    r.src = INT_HF;
    r.div_log2 = DIV_ONE;
    if (code >= IFS_DIV16) begin
      r.div_log2 = 4'(IFS_DIV1 - code);
    end else if (code == IFS_CODE2) begin
      r.src = mfsel ? INT_MF : INT_HF;
      r.div_log2 = mfsel ? DIV_ONE : DIV_HF_C2;
    end else if (code == IFS_CODE1) begin
      r.src = mfsel ? INT_MF : INT_HF;
      r.div_log2 = mfsel ? DIV_TWO : DIV_HF_C1;
    end else if (!lfsrc) begin
      r.src = INT_LF;
    end else begin
      r.src = mfsel ? INT_MF : INT_HF;
      r.div_log2 = mfsel ? DIV_MF_C0 : DIV_HF_C0;
    end
    decode_freq = r;
  endfunction

  // primary mode straight from the fuse field
  wire primary_is_internal = (fuse.primary_mode_fuse >= MODE_INT_FIRST) &&
                             (fuse.primary_mode_fuse <= MODE_INT_LAST);
  wire primary_is_external = fuse.primary_mode_fuse <= MODE_EXT_LAST;

  wire next_mult_sel = (primary_is_external && fuse.multiplier_fuse) ||
                       (!primary_is_external && multiplier_enable);

  // second pin role from fuse code
  wire pin_is_clkout = (fuse.primary_mode_fuse == MODE_CLKOUT_A) ||
                       (fuse.primary_mode_fuse == MODE_CLKOUT_B);
  wire pin_is_gpio = (fuse.primary_mode_fuse == MODE_GPIO_A) ||
                     (fuse.primary_mode_fuse == MODE_GPIO_B);
  wire scs_pin_role_t next_pin_role = pin_is_clkout ? PIN_CLKOUT :
                                      pin_is_gpio ? PIN_GPIO : PIN_OSC;

  // ----------------------------------------------------------------
  // clock switching
  // ----------------------------------------------------------------
  scs_sw_state_t sw_state;
  scs_sw_state_t next_sw_state;
  logic [2:0] sw_cnt;
  scs_src_t active_src;
  logic startup_pending;

  wire scs_src_t wanted_src = decode_select(sys_clock_select);
  wire sw_done = sw_cnt == 3'h1;

  always_comb begin
    next_sw_state = sw_state;
    unique case (sw_state)
      SW_STEADY: begin
        if (wanted_src != active_src) begin
          next_sw_state = SW_MOVING;
        end
      end
      SW_MOVING: begin
        if (sw_done) begin
          next_sw_state = SW_STEADY;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_state <= SW_STEADY;
      sw_cnt <= 3'h0;
      active_src <= SRC_PRIMARY;
    end else begin
      sw_state <= next_sw_state;
      sw_cnt <= (sw_state == SW_STEADY) ? SWITCH_CNT : sw_cnt - 3'h1;
      if (sw_state == SW_MOVING && sw_done) begin
        active_src <= wanted_src;
      end
    end
  end

  // primary not yet ready while two-speed start runs internally
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startup_pending <= 1'b1;
    end else if (primary_ready) begin
      startup_pending <= 1'b0;
    end
  end

  wire on_internal_startup = startup_pending && fuse.two_speed_startup_fuse;
  wire primary_live = active_src == SRC_PRIMARY && !on_internal_startup;

  // ----------------------------------------------------------------
  // status and outputs
  // ----------------------------------------------------------------
  logic [1:0] div4_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_running_status <= 1'b0;
      multiplier_running_status <= 1'b0;
      secondary_running_status <= 1'b0;
    end else begin
      primary_running_status <= primary_live && !primary_is_internal;
      multiplier_running_status <= primary_live && next_mult_sel;
      secondary_running_status <= active_src == SRC_SECONDARY;
    end
  end

  // outputs all registered; frequency follows code next cycle
  // frequency follows code one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_clock_source <= SRC_PRIMARY;
      // reset shows the 1 MHz setting, not the undivided rate
      int_clk_setting <= '{src: INT_HF, div_log2: 4'(IFS_DIV1 - IFS_RESET)};
      multiplier_select <= 1'b0;
      secondary_osc_enable <= 1'b0;
      primary_drive_enable <= PRIDRV_RESET;
      watchdog_low_osc_sel <= 1'b1;
      pin_role <= PIN_OSC;
      switch_busy <= 1'b0;
    end else begin
      sys_clock_source <= on_internal_startup && active_src == SRC_PRIMARY ? SRC_INTERNAL
                                                                             : active_src;
      int_clk_setting <= decode_freq(internal_freq_select, low_freq_source_bit,
                                     medium_osc_select);
      multiplier_select <= next_mult_sel;
      // stays on while anyone needs it
      secondary_osc_enable <= secondary_osc_start || secondary_other_req ||
                              active_src == SRC_SECONDARY || wanted_src == SRC_SECONDARY;
      primary_drive_enable <= primary_drive_on;
      watchdog_low_osc_sel <= 1'b1;
      pin_role <= next_pin_role;
      switch_busy <= next_sw_state == SW_MOVING;
    end
  end

  // divided clock: quarter rate only in clkout role
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div4_cnt <= 2'h0;
      divided_clock_output <= 1'b0;
    end else begin
      div4_cnt <= div4_cnt + 2'h1;
      divided_clock_output <= (next_pin_role == PIN_CLKOUT) && div4_cnt[1];
    end
  end

  // sleep instruction steering
  // idle versus sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_enter <= 1'b0;
      sleep_enter <= 1'b0;
    end else begin
      idle_enter <= sleep_exec && idle_on_sleep_enable;
      sleep_enter <= sleep_exec && !idle_on_sleep_enable;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_scs_decode_route: assert property (
    (sw_state == SW_MOVING && sw_done) |=> active_src == $past(wanted_src))
    else $error("active source differs from select field");
  chk_switch_interval: assert property (
    (sw_state == SW_STEADY && wanted_src != active_src) |=> switch_busy ##1 switch_busy
    ##1 (active_src == $past(wanted_src, 2)))
    else $error("clock switch interval wrong");
  chk_freq_high_div: assert property (
    (internal_freq_select >= IFS_DIV16) |=> (int_clk_setting.src == INT_HF &&
    int_clk_setting.div_log2 == 4'(IFS_DIV1 - $past(internal_freq_select))))
    else $error("high oscillator divider wrong");
  chk_freq_low_code: assert property (
    (internal_freq_select == 3'h0 && !low_freq_source_bit) |=> int_clk_setting.src == INT_LF)
    else $error("code zero not on low oscillator");
  chk_freq_hf_512: assert property (
    (internal_freq_select == 3'h0 && low_freq_source_bit && !medium_osc_select)
    |=> int_clk_setting.div_log2 == DIV_HF_C0)
    else $error("high oscillator /512 missing");
  chk_freq_medium: assert property (
    (internal_freq_select == IFS_CODE1 && medium_osc_select)
    |=> (int_clk_setting.src == INT_MF && int_clk_setting.div_log2 == DIV_TWO))
    else $error("medium oscillator /2 missing");
  chk_watchdog_low: assert property (
    watchdog_low_osc_sel)
    else $error("watchdog left low oscillator");
  chk_sleep_idle: assert property (
    sleep_exec |=> (idle_enter == $past(idle_on_sleep_enable)) && (idle_enter != sleep_enter))
    else $error("sleep steering wrong");
  chk_secondary_run: assert property (
    (active_src == SRC_SECONDARY) [*2] |-> secondary_running_status)
    else $error("secondary running flag missing");
  chk_secondary_hold: assert property (
    (active_src == SRC_SECONDARY) |=> secondary_osc_enable)
    else $error("secondary stopped while in use");
  chk_mult_fuse: assert property (
    (primary_is_external && fuse.multiplier_fuse) |=> multiplier_select)
    else $error("multiplier not selected by fuse");

  cov_switch_secondary: cover property (wr_main ##[1:8] active_src == SRC_SECONDARY);
  cov_switch_internal: cover property (switch_busy ##[1:4] active_src == SRC_INTERNAL);
  cov_idle_entry: cover property (idle_enter);
  cov_bad_address: cover property (pslverr);

endmodule // scs_clock_select

`default_nettype wire

/* test/scs_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none

// oscillator side: each one settles START_CYC cycles after it is turned on
module scs_osc_model
  import scs_pkg::*;
#(
  parameter int START_CYC = 6
)(
  input wire logic clk,
  input wire logic [2:0] osc_on,
  input wire scs_fuse_t fuse_set,
  output logic [2:0] osc_stable_raw,
  output scs_fuse_t fuse_raw,
  output logic primary_ready_raw
);
  int cnt [3];

  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      cnt[i] = osc_on[i] ? ((cnt[i] < START_CYC) ? cnt[i] + 1 : cnt[i]) : 0;
      osc_stable_raw[i] <= (cnt[i] == START_CYC); // drops at once when turned off
    end
  end

  // fuse field as the bench sets it
  assign fuse_raw = fuse_set;
  assign primary_ready_raw = 1'b1;
endmodule // scs_osc_model

`default_nettype wire

/* test/tb_system_clock_source_select.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_system_clock_source_select
  import scs_pkg::*;
;
  logic clk, resetn = 0, por_resetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_exec = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, se, mult, sec_en, drv, wdt, dco, busy, idle_e, sleep_e, prdy;
  logic [2:0] osc_on = 0, stab;
  logic other_req = 0;
  scs_fuse_t fuse, fuse_cfg = '{4'h2, 1'b0, 1'b0};
  scs_src_t src;
  scs_int_clk_t ics;
  scs_pin_role_t role;
  int err_count = 0, n_tests = 0, seed = 32'hDF67768C;
  int sels [4] = '{1, 3, 2, 0};

  scs_clock_select dut (.clk(clk), .resetn(resetn), .por_resetn(por_resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuse_raw(fuse), .osc_stable_raw(stab),
    .primary_ready_raw(prdy), .secondary_other_req(other_req), .sleep_exec(sleep_exec),
    .sys_clock_source(src), .int_clk_setting(ics), .multiplier_select(mult),
    .secondary_osc_enable(sec_en), .primary_drive_enable(drv), .watchdog_low_osc_sel(wdt),
    .pin_role(role), .divided_clock_output(dco), .switch_busy(busy), .idle_enter(idle_e),
    .sleep_enter(sleep_e));
  scs_osc_model osc (.clk(clk), .osc_on(osc_on), .fuse_set(fuse_cfg), .osc_stable_raw(stab),
    .fuse_raw(fuse),
    .primary_ready_raw(prdy));

  // ----------------------------------------------------------------
  // bench tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task end_sim;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // apb master: hold the request until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    apb(0, a, 0);
    chk(rd & m, e, s);
  endtask

  task rst(input logic por);
    @(posedge clk);
    resetn <= 0;
    por_resetn <= !por;
    repeat (12) @(posedge clk);
    resetn <= 1;
    por_resetn <= 1;
    repeat (8) @(posedge clk);
  endtask

  // settle: switch interval is bounded, never a bare wait on busy
  task wait_switch;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 20 && busy === 1'b1; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask

  // reference mapping of the frequency field
  function logic [5:0] exp_clk(int code, int lf, int mf);
    int s, d;
    if (code >= 3) begin
      s = INT_HF;
      d = 7 - code;
    end else if (code == 0 && lf == 0) begin
      s = INT_LF;
      d = 0;
    end else if (mf != 0) begin
      s = INT_MF;
      d = (code == 0) ? 4 : 2 - code;
    end else begin
      s = INT_HF;
      d = (code == 0) ? 9 : 7 - code;
    end
    return {2'(s), 4'(d)};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic idle, ie, sl;
    int ones;
    repeat (12) @(posedge clk);
    resetn <= 1;
    por_resetn <= 1;
    osc_on <= 3'h5;
    repeat (14) @(posedge clk);
    rdchk(MAIN_CTRL_OFFS, 32'hFFFFFFFF, 32'h3C, "main reset");
    rdchk(AUX_CTRL_OFFS, 32'hFFFFFFFF, 32'h05, "aux reset");
    osc_on <= 3'h2;
    repeat (14) @(posedge clk);
    rdchk(MAIN_CTRL_OFFS, 32'h04, 32'h0, "hf stable");
    rdchk(AUX_CTRL_OFFS, 32'h03, 32'h2, "mf lf stable");
    chk(wdt, 1, "watchdog osc");
    chk(ics, {INT_HF, 4'h4}, "default freq");
    chk({role, dco}, {PIN_OSC, 1'b0}, "pin role");
    apb(1, 8'h0C, 32'hFF);
    chk({se, rd}, {1'b1, 32'h0}, "unmapped");
    foreach (sels[i]) begin
      apb(1, MAIN_CTRL_OFFS, 32'h30 | sels[i]);
      wait_switch();
      chk(src, (sels[i] == 0) ? SRC_PRIMARY : (sels[i] == 1) ? SRC_SECONDARY : SRC_INTERNAL,
        "source");
      rdchk(AUX_CTRL_OFFS, 32'hC0, (sels[i] == 1) ? 32'h40 : 32'h0, "sec run");
      rdchk(MAIN_CTRL_OFFS, 32'h08, (sels[i] == 0) ? 32'h08 : 32'h0, "pri run");
    end
    for (int lm = 0; lm < 4; lm++) begin
      apb(1, TUNE_CTRL_OFFS, ((lm & 1) << 7) | 32'h40);
      apb(1, AUX_CTRL_OFFS, ((lm >> 1) << 4) | 32'h04);
      chk(mult, 0, "multiplier");
      for (int c = 0; c < 8; c++) begin
        apb(1, MAIN_CTRL_OFFS, (c << 4) | 2);
        repeat (2) @(negedge clk);
        chk(ics, exp_clk(c, lm & 1, lm >> 1), "freq map");
      end
    end
    // fuse-driven pin role and multiplier choice
    @(posedge clk);
    fuse_cfg <= '{4'h9, 1'b0, 1'b0};
    repeat (6) @(negedge clk);
    chk({role, mult}, {PIN_CLKOUT, 1'b1}, "internal mode fuse");
    ones = 0;
    repeat (4) begin
      @(negedge clk);
      ones += dco;
    end
    chk(ones, 2, "clkout quarter rate");
    @(posedge clk);
    fuse_cfg <= '{4'h5, 1'b1, 1'b0};
    apb(1, MAIN_CTRL_OFFS, 32'h30);
    wait_switch();
    chk({role, mult}, {PIN_GPIO, 1'b1}, "external mode fuse");
    rdchk(AUX_CTRL_OFFS, 32'h80, 32'h80, "mult run");
    rdchk(MAIN_CTRL_OFFS, 32'h08, 32'h08, "ext pri run");
    @(posedge clk);
    fuse_cfg <= '{4'h2, 1'b0, 1'b0};
    repeat (6) begin
      idle = $random(seed);
      apb(1, MAIN_CTRL_OFFS, {24'h0, idle, 7'h32});
      @(posedge clk);
      sleep_exec <= 1;
      @(posedge clk);
      sleep_exec <= 0;
      ie = 0;
      sl = 0;
      repeat (3) begin
        @(negedge clk);
        ie |= idle_e;
        sl |= sleep_e;
      end
      chk({ie, sl}, {idle, !idle}, "sleep kind");
    end
    apb(1, AUX_CTRL_OFFS, 32'h08);
    apb(1, MAIN_CTRL_OFFS, 32'h31);
    wait_switch();
    chk({sec_en, drv}, 2'b10, "aux outputs");
    rst(0);
    rdchk(MAIN_CTRL_OFFS, 32'h73, 32'h30, "warm reset main");
    rdchk(AUX_CTRL_OFFS, 32'h0C, 32'h0C, "warm reset aux");
    apb(1, AUX_CTRL_OFFS, 32'h04);
    repeat (3) @(negedge clk);
    chk(sec_en, 0, "secondary off");
    @(posedge clk);
    other_req <= 1;
    repeat (2) @(negedge clk);
    chk(sec_en, 1, "other requester");
    @(posedge clk);
    other_req <= 0;
    apb(1, AUX_CTRL_OFFS, 32'h0C);
    rst(1);
    rdchk(AUX_CTRL_OFFS, 32'h08, 32'h0, "por aux");
    end_sim();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule // tb_system_clock_source_select

`default_nettype wire
